// ==== core/tmr2w_pkg.sv ====
/*
 Constants for the timer with auto-reload and suspend wake-up: register
 offsets, field positions, reset values and divider counts.
 Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
*/
package tmr2w_pkg;
	localparam int          ADDR_W        = 8;
	localparam logic [7:0]  OFF_CTRL      = 8'h00;
	localparam logic [7:0]  OFF_CNT_LO    = 8'h04;
	localparam logic [7:0]  OFF_CNT_HI    = 8'h08;
	localparam logic [7:0]  OFF_RL_LO     = 8'h0C;
	localparam logic [7:0]  OFF_RL_HI     = 8'h10;
	localparam logic [7:0]  OFF_OSC       = 8'h14;
	localparam logic [7:0]  OFF_IE        = 8'h18;
	localparam logic [7:0]  OFF_STAT      = 8'h1C;
	localparam logic [7:0]  OFF_MASK      = 8'h20;
	localparam logic [7:0]  OFF_CAP       = 8'h24;
	localparam int          CTRL_HI_OVF   = 7;
	localparam int          CTRL_LO_OVF   = 6;
	localparam int          CTRL_LO_IE    = 5;
	localparam int          CTRL_CAP_EN   = 4;
	localparam int          CTRL_SPLIT    = 3;
	localparam int          CTRL_RUN      = 2;
	localparam int          IE_TMR        = 5;
	localparam int          OSC_SYNC      = 0;
	localparam int          ST_HI         = 0;
	localparam int          ST_LO         = 1;
	localparam int          ST_CAP        = 2;
	localparam int          ST_WAKE       = 3;
	localparam logic [7:0]  CTRL_RST      = 8'h00;
	localparam logic [7:0]  BYTE_RST      = 8'h00;
	localparam logic [3:0]  STAT_RST      = 4'h0;
	localparam logic [3:0]  DIV12_LAST    = 4'hB;
	localparam logic [2:0]  DIV8_LAST     = 3'h7;
	localparam logic [1:0]  SYNC_LAST     = 2'h2;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	typedef enum logic [1:0] {SRC_SYS, SRC_DIV12, SRC_EXT8} tmr2w_src_t;
endpackage : tmr2w_pkg

// ==== core/tmr2w_sync.sv ====
/*
 Three-stage input synchroniser with agreement filter and rise pulse.
 Assumes the input is asynchronous to clk; output follows two agreeing stages.
*/
module tmr2w_sync (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic async_in,
	output logic      level,
	output logic      rise
);
	import tmr2w_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic rise;
	} tmr2w_sync_t;

	tmr2w_sync_t r_reg;
	tmr2w_sync_t r_next;

	always_comb
	begin
		r_next      = r_reg;
		r_next.s1   = async_in;
		r_next.s2   = r_reg.s1;
		r_next.s3   = r_reg.s2;
		r_next.rise = 1'b0;
		// Only stages two and three decide; stage one may be metastable
		if (r_reg.s2 == r_reg.s3)
		begin
			r_next.lvl  = r_reg.s3;
			r_next.rise = r_reg.s3 & ~r_reg.lvl;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign level = r_reg.lvl;
	assign rise  = r_reg.rise;
endmodule : tmr2w_sync

// ==== core/tmr2w_timer.sv ====
/*
 Timer with 16-bit or split 8-bit auto-reload, comparator capture,
 three count sources and suspend wake-up, behind an AXI4-Lite slave.
 Assumes ext_osc and cmp_out are asynchronous pins and suspend is a
 level from the clock controller on aclk.
// How it works
// - Counter is two byte registers, low and high
// - Control bit 3 picks 16-bit or split mode
// - Comparator rising edge captures current count
// - Count source: clock, clock/12, external/8
// - External/8 source synchronised outside suspend
// - In suspend external/8 keeps counting up
// - Overflow during suspend raises wake-up
// - Sync pending up to three ticks after wake
// - 16-bit rollover reloads and sets high flag
// - Timer interrupt enable gates every overflow
// - Low-byte interrupt also needs its own enable
*/
module tmr2w_timer
	import tmr2w_pkg::*;
#(
	parameter int AW = tmr2w_pkg::ADDR_W
)(
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic [AW-1:0] s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [AW-1:0] s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	input  wire logic          ext_osc,
	input  wire logic          cmp_out,
	input  wire logic          suspend,
	output logic               wake_req,
	output logic               irq
);
	import tmr2w_pkg::*;

	// Decode compares AW-1:2 against 8-bit offsets; 0x24 needs six bits
	if (AW < 6 || AW > 8)
	begin : g_aw_check
		$error("AW must be 6 to 8 for the register map");
	end

	typedef struct packed {
		logic [7:0]    ctrl;
		logic [7:0]    lo;
		logic [7:0]    hi;
		logic [7:0]    rl_lo;
		logic [7:0]    rl_hi;
		logic [7:0]    ie;
		logic [3:0]    stat;
		logic [3:0]    mask;
		logic [15:0]   cap;
		logic [3:0]    d12;
		logic [2:0]    d8;
		logic          pend;
		logic [1:0]    pend_cnt;
		logic          wake;
		logic          susp_d;
		logic          aw_have;
		logic [AW-1:0] aw_addr;
		logic          w_have;
		logic [31:0]   wdata;
		logic          wstrb0;
		logic          bvalid;
		logic [1:0]    bresp;
		logic          rvalid;
		logic [31:0]   rdata;
		logic [1:0]    rresp;
	} tmr2w_state_t;

	tmr2w_state_t r_reg;
	tmr2w_state_t r_next;

	logic       ext_rise;
	logic       cmp_rise;
	logic       tick12;
	logic       tick_ext;
	logic       tick;
	logic       split;
	logic       wr_do;
	logic       wr_cnt;
	logic       set_hi;
	logic       set_lo;
	tmr2w_src_t src;

	function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] off);
		hit = (a[AW-1:2] == off[AW-1:2]);
	endfunction : hit

	function automatic logic mapped(input logic [AW-1:0] a);
		mapped = hit(a, OFF_CTRL) | hit(a, OFF_CNT_LO) | hit(a, OFF_CNT_HI)
			| hit(a, OFF_RL_LO) | hit(a, OFF_RL_HI) | hit(a, OFF_OSC)
			| hit(a, OFF_IE) | hit(a, OFF_STAT) | hit(a, OFF_MASK)
			| hit(a, OFF_CAP);
	endfunction : mapped

	// External oscillator passes four flops, three sync stages and the rise flop, before any edge counts
	tmr2w_sync u_ext_sync (
		.clk      (aclk),
		.resetn   (aresetn),
		.async_in (ext_osc),
		.level    (),
		.rise     (ext_rise)
	);

	tmr2w_sync u_cmp_sync (
		.clk      (aclk),
		.resetn   (aresetn),
		.async_in (cmp_out),
		.level    (),
		.rise     (cmp_rise)
	);

	assign src      = tmr2w_src_t'(r_reg.ctrl[1:0]);
	assign split    = r_reg.ctrl[CTRL_SPLIT];
	assign tick12   = (r_reg.d12 == DIV12_LAST);
	assign tick_ext = ext_rise & (r_reg.d8 == DIV8_LAST);
	assign wr_do    = r_reg.aw_have & r_reg.w_have & ~r_reg.bvalid;
	assign wr_cnt   = wr_do & r_reg.wstrb0
		& (hit(r_reg.aw_addr, OFF_CNT_LO) | hit(r_reg.aw_addr, OFF_CNT_HI));

	// Count tick; in suspend only the external/8 source is alive
	always_comb
	begin
		tick = 1'b0;
		if (r_reg.ctrl[CTRL_RUN])
		begin
			if (suspend)
				tick = tick_ext;
			else
			begin
				unique case (src)
					SRC_SYS:   tick = 1'b1;
					SRC_DIV12: tick = tick12;
					SRC_EXT8:  tick = tick_ext;
					default:   tick = 1'b0;
				endcase
			end
		end
	end

	always_comb
	begin
		logic [15:0] cnt;
		logic [3:0]  st_set;
		logic [3:0]  st_clr;
		cnt    = {r_reg.hi, r_reg.lo};
		st_set = 4'h0;
		st_clr = 4'h0;
		set_hi = 1'b0;
		set_lo = 1'b0;
		r_next = r_reg;

		r_next.d12    = tick12 ? 4'h0 : 4'(r_reg.d12 + 4'h1);
		r_next.d8     = ext_rise ? 3'(r_reg.d8 + 3'h1) : r_reg.d8;
		r_next.susp_d = suspend;

		if (tick)
		begin
			if (!split)
			begin
				set_lo = (r_reg.lo == 8'hFF);
				if (cnt == 16'hFFFF)
				begin
					{r_next.hi, r_next.lo} = {r_reg.rl_hi, r_reg.rl_lo};
					set_hi = 1'b1;
				end
				else
					{r_next.hi, r_next.lo} = 16'(cnt + 16'h0001);
			end
			else
			begin
				set_lo = (r_reg.lo == 8'hFF);
				set_hi = (r_reg.hi == 8'hFF);
				r_next.lo = set_lo ? r_reg.rl_lo : 8'(r_reg.lo + 8'h01);
				r_next.hi = set_hi ? r_reg.rl_hi : 8'(r_reg.hi + 8'h01);
			end
		end

		if (r_reg.ctrl[CTRL_CAP_EN] && cmp_rise)
		begin
			r_next.cap = cnt;
			st_set[ST_CAP] = 1'b1;
		end

		// Wake is held until the clock controller leaves suspend
		if (suspend && set_hi)
		begin
			r_next.wake = 1'b1;
			st_set[ST_WAKE] = 1'b1;
		end
		else if (!suspend)
			r_next.wake = 1'b0;

		if (r_reg.susp_d && !suspend && !r_reg.wake)
		begin
			r_next.pend     = 1'b1;
			r_next.pend_cnt = 2'h0;
		end
		else if (r_reg.pend && tick_ext)
		begin
			r_next.pend_cnt = 2'(r_reg.pend_cnt + 2'h1);
			if (r_reg.pend_cnt == SYNC_LAST)
				r_next.pend = 1'b0;
		end
		st_set[ST_HI] = set_hi;
		st_set[ST_LO] = set_lo;

		if (s_axi_awvalid && s_axi_awready)
		begin
			r_next.aw_have = 1'b1;
			r_next.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			r_next.w_have = 1'b1;
			r_next.wdata  = s_axi_wdata;
			r_next.wstrb0 = s_axi_wstrb[0];
		end
		if (r_reg.bvalid && s_axi_bready)
			r_next.bvalid = 1'b0;

		if (wr_do)
		begin
			r_next.aw_have = 1'b0;
			r_next.w_have  = 1'b0;
			r_next.bvalid  = 1'b1;
			r_next.bresp   = mapped(r_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			// Registers are one byte wide; only lane 0 writes them
			if (r_reg.wstrb0)
			begin
				if (hit(r_reg.aw_addr, OFF_CTRL))
					r_next.ctrl = r_reg.wdata[7:0];
				if (hit(r_reg.aw_addr, OFF_CNT_LO))
					r_next.lo = r_reg.wdata[7:0];
				if (hit(r_reg.aw_addr, OFF_CNT_HI))
					r_next.hi = r_reg.wdata[7:0];
				if (hit(r_reg.aw_addr, OFF_RL_LO))
					r_next.rl_lo = r_reg.wdata[7:0];
				if (hit(r_reg.aw_addr, OFF_RL_HI))
					r_next.rl_hi = r_reg.wdata[7:0];
				if (hit(r_reg.aw_addr, OFF_IE))
					r_next.ie = r_reg.wdata[7:0];
				if (hit(r_reg.aw_addr, OFF_STAT))
					st_clr = r_reg.wdata[3:0];
				if (hit(r_reg.aw_addr, OFF_MASK))
					r_next.mask = r_reg.wdata[3:0];
			end
		end

		// Hardware set beats a software clear in the same cycle
		r_next.ctrl[CTRL_HI_OVF] = r_next.ctrl[CTRL_HI_OVF] | set_hi;
		r_next.ctrl[CTRL_LO_OVF] = r_next.ctrl[CTRL_LO_OVF] | set_lo;
		r_next.stat = (r_reg.stat & ~st_clr) | st_set;

		if (r_reg.rvalid && s_axi_rready)
			r_next.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			r_next.rdata  = 32'h0000_0000;
			if (hit(s_axi_araddr, OFF_CTRL))
				r_next.rdata[7:0] = r_reg.ctrl;
			if (hit(s_axi_araddr, OFF_CNT_LO))
				r_next.rdata[7:0] = r_reg.lo;
			if (hit(s_axi_araddr, OFF_CNT_HI))
				r_next.rdata[7:0] = r_reg.hi;
			if (hit(s_axi_araddr, OFF_RL_LO))
				r_next.rdata[7:0] = r_reg.rl_lo;
			if (hit(s_axi_araddr, OFF_RL_HI))
				r_next.rdata[7:0] = r_reg.rl_hi;
			if (hit(s_axi_araddr, OFF_OSC))
				r_next.rdata[OSC_SYNC] = r_reg.pend;
			if (hit(s_axi_araddr, OFF_IE))
				r_next.rdata[7:0] = r_reg.ie;
			if (hit(s_axi_araddr, OFF_STAT))
				r_next.rdata[3:0] = r_reg.stat;
			if (hit(s_axi_araddr, OFF_MASK))
				r_next.rdata[3:0] = r_reg.mask;
			if (hit(s_axi_araddr, OFF_CAP))
				r_next.rdata[15:0] = r_reg.cap;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			r_reg       <= '0;
			r_reg.ctrl  <= CTRL_RST;
			r_reg.ie    <= BYTE_RST;
			r_reg.stat  <= STAT_RST;
			r_reg.mask  <= STAT_RST;
		end
		else
			r_reg <= r_next;
	end

	assign s_axi_awready = ~r_reg.aw_have & ~r_reg.bvalid;
	assign s_axi_wready  = ~r_reg.w_have & ~r_reg.bvalid;
	assign s_axi_bvalid  = r_reg.bvalid;
	assign s_axi_bresp   = r_reg.bresp;
	assign s_axi_arready = ~r_reg.rvalid;
	assign s_axi_rvalid  = r_reg.rvalid;
	assign s_axi_rdata   = r_reg.rdata;
	assign s_axi_rresp   = r_reg.rresp;
	assign wake_req      = r_reg.wake;

	// Low-byte events need the extra enable on top of the timer enable
	assign irq = r_reg.ie[IE_TMR] & (
		(r_reg.stat[ST_HI] & r_reg.mask[ST_HI])
		| (r_reg.stat[ST_LO] & r_reg.mask[ST_LO] & r_reg.ctrl[CTRL_LO_IE])
		| (r_reg.stat[ST_CAP] & r_reg.mask[ST_CAP])
		| (r_reg.stat[ST_WAKE] & r_reg.mask[ST_WAKE]));

	property p_reload16;
		@(posedge aclk) disable iff (!aresetn)
		tick && !split && {r_reg.hi, r_reg.lo} == 16'hFFFF && !wr_cnt
		|=> {r_reg.hi, r_reg.lo} == {$past(r_reg.rl_hi), $past(r_reg.rl_lo)}
			&& r_reg.ctrl[CTRL_HI_OVF];
	endproperty
	a_reload16: assert property (p_reload16) else $error("16-bit reload wrong");

	property p_inc16;
		@(posedge aclk) disable iff (!aresetn)
		tick && !split && {r_reg.hi, r_reg.lo} != 16'hFFFF && !wr_cnt
		|=> {r_reg.hi, r_reg.lo} == 16'($past({r_reg.hi, r_reg.lo}) + 16'h0001);
	endproperty
	a_inc16: assert property (p_inc16) else $error("16-bit increment wrong");

	property p_split_lo;
		@(posedge aclk) disable iff (!aresetn)
		tick && split && r_reg.lo == 8'hFF && r_reg.hi != 8'hFF && !wr_cnt
		|=> r_reg.lo == $past(r_reg.rl_lo) && r_reg.ctrl[CTRL_LO_OVF]
			&& r_reg.hi == 8'($past(r_reg.hi) + 8'h01);
	endproperty
	a_split_lo: assert property (p_split_lo) else $error("split low reload wrong");

	property p_capture;
		@(posedge aclk) disable iff (!aresetn)
		r_reg.ctrl[CTRL_CAP_EN] && cmp_rise
		|=> r_reg.cap == $past({r_reg.hi, r_reg.lo}) && r_reg.stat[ST_CAP];
	endproperty
	a_capture: assert property (p_capture) else $error("capture missed");

	property p_div12;
		@(posedge aclk) disable iff (!aresetn)
		tick12 |=> (!tick12)[*8] ##1 (!tick12)[*3] ##1 tick12;
	endproperty
	a_div12: assert property (p_div12) else $error("divide-by-12 spacing wrong");

	property p_susp_src;
		@(posedge aclk) disable iff (!aresetn)
		suspend && !tick_ext |-> !tick;
	endproperty
	a_susp_src: assert property (p_susp_src) else $error("non-external tick in suspend");

	property p_wake;
		@(posedge aclk) disable iff (!aresetn)
		suspend && tick && !split && {r_reg.hi, r_reg.lo} == 16'hFFFF
		|=> wake_req;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on overflow");

	property p_sync_set;
		@(posedge aclk) disable iff (!aresetn)
		r_reg.susp_d && !suspend && !wake_req |=> r_reg.pend;
	endproperty
	a_sync_set: assert property (p_sync_set) else $error("sync pending not set");

	property p_sync_clr;
		@(posedge aclk) disable iff (!aresetn)
		r_reg.pend && tick_ext && r_reg.pend_cnt == SYNC_LAST && !(r_reg.susp_d && !suspend)
		|=> !r_reg.pend;
	endproperty
	a_sync_clr: assert property (p_sync_clr) else $error("sync pending stuck");

	property p_irq_gate;
		@(posedge aclk) disable iff (!aresetn)
		irq |-> r_reg.ie[IE_TMR]
			&& !(r_reg.stat == 4'h2 && !r_reg.ctrl[CTRL_LO_IE]);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");
endmodule : tmr2w_timer

// ==== verif/tmr2w_timer_tb.sv ====
/*
 Self-checking bench for the auto-reload wake-up timer: AXI4-Lite tasks,
 reload, split, interrupt, capture, source and suspend scenarios.
 Assumes the package and timer module are compiled first.
*/
module tmr2w_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import tmr2w_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn;
	logic [7:0]  s_axi_awaddr;
	logic        s_axi_awvalid;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_wvalid;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready;
	logic [7:0]  s_axi_araddr;
	logic        s_axi_arvalid;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready;
	logic        ext_osc;
	logic        cmp_out;
	logic        suspend;
	logic        wake_req;
	logic        irq;
	logic [1:0]  ext_div;
	logic [1:0]  bresp_seen;
	logic [1:0]  rresp_seen;
	logic [31:0] rdata_seen;
	logic [31:0] cap_seen;
	int          failures;
	int          samples_checked;
	int          n;

	tmr2w_timer u_tmr2w_timer (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .ext_osc(ext_osc), .cmp_out(cmp_out),
		.suspend(suspend), .wake_req(wake_req), .irq(irq)
	);

	always #2 aclk = ~aclk;

	// External oscillator at one sixth of the bus clock
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ext_div <= 2'h0;
			ext_osc <= 1'b0;
		end
		else if (ext_div == 2'h2)
		begin
			ext_div <= 2'h0;
			ext_osc <= ~ext_osc;
		end
		else
			ext_div <= ext_div + 2'h1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Ready is sampled at the falling edge, stable until the taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ha;
		logic hw;
		logic da;
		logic dw;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		da = 1'b0;
		dw = 1'b0;
		while (!(da && dw))
		begin
			@(negedge aclk);
			ha = s_axi_awvalid && s_axi_awready;
			hw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (ha)
				s_axi_awvalid <= 1'b0;
			if (hw)
				s_axi_wvalid <= 1'b0;
			da = da || ha;
			dw = dw || hw;
		end
		ha = 1'b0;
		while (!ha)
		begin
			@(negedge aclk);
			ha = s_axi_bvalid;
			bresp_seen = s_axi_bresp;
			@(posedge aclk);
		end
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic h;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		h = 1'b0;
		while (!h)
		begin
			@(negedge aclk);
			h = s_axi_arready;
			@(posedge aclk);
		end
		s_axi_arvalid <= 1'b0;
		h = 1'b0;
		while (!h)
		begin
			@(negedge aclk);
			h = s_axi_rvalid;
			rdata_seen = s_axi_rdata;
			rresp_seen = s_axi_rresp;
			@(posedge aclk);
		end
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rdata_seen, e);
	endtask : rc

	task automatic irq_is(input logic e);
		@(negedge aclk);
		chk({31'h0, irq}, {31'h0, e});
		@(posedge aclk);
	endtask : irq_is

	task automatic final_report;
		$display("checks %0d, failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report

	initial
	begin
		#40000;
		failures++;
		final_report();
	end

	initial
	begin
		{aresetn, cmp_out, suspend} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_wstrb = 4'hF;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		rc(OFF_CTRL, 32'h0);
		rc(OFF_MASK, 32'h0);
		rd(8'h40);
		chk({30'h0, rresp_seen}, {30'h0, RESP_SLVERR});
		wr(8'h40, 32'h1);
		chk({30'h0, bresp_seen}, {30'h0, RESP_SLVERR});
		wr(OFF_CNT_LO, 32'h15A);
		chk({30'h0, bresp_seen}, {30'h0, RESP_OKAY});
		wr(OFF_CNT_HI, 32'hA5);
		rc(OFF_CNT_LO, 32'h5A);
		chk({30'h0, rresp_seen}, {30'h0, RESP_OKAY});
		rc(OFF_CNT_HI, 32'hA5);
		// Lane 0 strobe low: byte registers must keep their value
		s_axi_wstrb <= 4'hE;
		wr(OFF_CNT_LO, 32'h77);
		s_axi_wstrb <= 4'hF;
		rc(OFF_CNT_LO, 32'h5A);
		// Rollover at 0xFFFF must reload, not wrap to zero
		wr(OFF_RL_LO, 32'h34);
		wr(OFF_RL_HI, 32'h12);
		wr(OFF_CNT_HI, 32'hFF);
		wr(OFF_CNT_LO, 32'hF0);
		wr(OFF_CTRL, 32'h04);
		repeat (40) @(posedge aclk);
		rc(OFF_CTRL, 32'hC4);
		wr(OFF_CTRL, 32'h03);
		rc(OFF_CNT_HI, 32'h12);
		rc(OFF_STAT, 32'h3);
		wr(OFF_MASK, 32'h1);
		irq_is(1'b0);
		wr(OFF_IE, 32'h20);
		irq_is(1'b1);
		wr(OFF_MASK, 32'h2);
		irq_is(1'b0);
		wr(OFF_CTRL, 32'h23);
		irq_is(1'b1);
		wr(OFF_STAT, 32'h3);
		irq_is(1'b0);
		rc(OFF_STAT, 32'h0);
		// Split: low half reloads from its own byte, high half keeps counting on
		wr(OFF_RL_LO, 32'h10);
		wr(OFF_RL_HI, 32'h20);
		wr(OFF_CNT_LO, 32'hFE);
		wr(OFF_CNT_HI, 32'hF0);
		wr(OFF_CTRL, 32'h0C);
		wr(OFF_CTRL, 32'h0B);
		// Writing control overwrites the flag; status keeps the low event
		rc(OFF_CTRL, 32'h0B);
		rc(OFF_STAT, 32'h2);
		rd(OFF_CNT_LO);
		chk({28'h0, rdata_seen[7:4]}, 32'h1);
		rd(OFF_CNT_HI);
		chk({28'h0, rdata_seen[7:4]}, 32'hF);
		wr(OFF_STAT, 32'hF);
		wr(OFF_CNT_LO, 32'h0);
		wr(OFF_CNT_HI, 32'h0);
		wr(OFF_CTRL, 32'h14);
		cmp_out <= 1'b1;
		repeat (10) @(posedge aclk);
		cmp_out <= 1'b0;
		wr(OFF_CTRL, 32'h13);
		rc(OFF_STAT, 32'h4);
		rd(OFF_CAP);
		cap_seen = rdata_seen;
		rd(OFF_CNT_LO);
		chk({31'h0, cap_seen != 32'h0 && cap_seen < rdata_seen}, 32'h1);
		// Divided sources: a whole-clock source would run far past these
		wr(OFF_CNT_LO, 32'h0);
		wr(OFF_CTRL, 32'h05);
		repeat (240) @(posedge aclk);
		wr(OFF_CTRL, 32'h07);
		rd(OFF_CNT_LO);
		chk({31'h0, rdata_seen inside {[32'h13:32'h16]}}, 32'h1);
		wr(OFF_CNT_LO, 32'h0);
		wr(OFF_CTRL, 32'h06);
		repeat (480) @(posedge aclk);
		wr(OFF_CTRL, 32'h07);
		rd(OFF_CNT_LO);
		chk({31'h0, rdata_seen inside {[32'h9:32'hB]}}, 32'h1);
		// Preloaded two counts short of overflow, then suspended
		wr(OFF_STAT, 32'hF);
		wr(OFF_CNT_LO, 32'hFE);
		wr(OFF_CNT_HI, 32'hFF);
		wr(OFF_CTRL, 32'h06);
		suspend <= 1'b1;
		n = 0;
		while (wake_req !== 1'b1 && n < 400)
		begin
			@(negedge aclk);
			n++;
		end
		chk({31'h0, wake_req}, 32'h1);
		rc(OFF_STAT, 32'hB);
		suspend <= 1'b0;
		repeat (2) @(posedge aclk);
		chk({31'h0, wake_req}, 32'h0);
		rc(OFF_OSC, 32'h0);
		// Wake by another source leaves the sync flag up for a while
		wr(OFF_CNT_HI, 32'h0);
		suspend <= 1'b1;
		repeat (20) @(posedge aclk);
		suspend <= 1'b0;
		repeat (2) @(posedge aclk);
		rc(OFF_OSC, 32'h1);
		repeat (220) @(posedge aclk);
		rc(OFF_OSC, 32'h0);
		final_report();
	end
endmodule : tmr2w_timer_tb
